// [dv/sfpc_prog_model.sv]
// Behavioural external programmer driving the serial link
module sfpc_prog_model (
  // Programmer link
  output logic prog_serial_clock,
  output logic prog_serial_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Bit and frame transmission
  // ****************************************************************
  initial begin
    prog_serial_clock = 1'b0;
    prog_serial_data = 1'b0;
  end

  // Data changes with the rise and is taken at the fall
  task automatic put_bit(input logic b);
    prog_serial_clock = 1'b1;
    prog_serial_data = b;
    #62.5;
    prog_serial_clock = 1'b0;
    #62.5;
  endtask

  // Code LSB first; code 0000 is followed by the instruction
  task automatic frame(input logic [3:0] code, input logic [23:0] ins);
    for (int i = 0; i < 4; i++) begin
      put_bit(code[i]);
    end
    if (code == 4'h0) begin
      for (int i = 0; i < 24; i++) begin
        put_bit(ins[i]);
      end
    end
    // Released line shows the inverse of the last bit, clock stands low
    prog_serial_data = ~prog_serial_data;
  endtask
endmodule // sfpc_prog_model

// [dv/tb_sfpc.sv]
// Self-checking bench of the serial flash program control
module tb_sfpc;
  timeunit 1ns;
  timeprecision 1ps;
  import sfpc_pkg::*;

  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  wire sclk, sdata;
  logic nv_running;
  sfpc_op_t nv_op;
  logic [15:0] row_lo, row_hi;
  int n_mismatch, n_checks;
  localparam logic [15:0] CODES [15] = '{16'h407F, 16'h4075, 16'h4074,
    16'h4072, 16'h4071, 16'h406E, 16'h405E, 16'h404E, 16'h4066, 16'h4056,
    16'h4046, 16'h4008, 16'h4005, 16'h4004, 16'h4001};

  sfpc_top sfpc_top_i (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prog_serial_clock(sclk), .prog_serial_data(sdata),
    .nv_running(nv_running), .nv_op(nv_op), .nv_row_addr_low(row_lo),
    .nv_row_addr_high(row_hi));
  sfpc_prog_model sfpc_prog_model_i (.prog_serial_clock(sclk),
    .prog_serial_data(sdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_mismatch++;
      wrap_up();
    end
    #1;
  endtask

  task automatic unlock();
    apb(1'b1, ADDR_KEY, 32'h0000_0055);
    apb(1'b1, ADDR_KEY, 32'h0000_00AA);
  endtask

  // Serial instruction, then poll status until the link is idle
  task automatic ser(input logic [3:0] op, input logic [3:0] sel,
                     input logic [15:0] d);
    int n;
    sfpc_prog_model_i.frame(CODE_EXEC, {op, sel, d});
    for (n = 0; n < 20; n++) begin
      apb(1'b0, ADDR_STAT, 32'h0000_0000);
      if (rd[8:7] === 2'b00) break;
    end
    if (n >= 20) begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    n_mismatch = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (CODES[i]) begin
      apb(1'b0, 8'(4 * (i % 5)), 32'h0000_0000);
      chk(rd, {16'h0000, CTL_RESET});
    end
    chk(32'({nv_running, nv_op}), 32'h0000_0000);
    apb(1'b1, 8'h20, 32'h0000_FFFF);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, ADDR_CTL, 32'h0000_C07F);
    apb(1'b0, ADDR_CTL, 32'h0000_0000);
    chk({nv_running, rd[30:0]}, 32'h0000_407F);
    apb(1'b1, ADDR_KEY, 32'h0000_00AA);
    apb(1'b1, ADDR_KEY, 32'h0000_0055);
    apb(1'b0, ADDR_STAT, 32'h0000_0000);
    chk(32'(rd[6:5]), 32'(KEY_HALF));
    apb(1'b1, ADDR_CTL, 32'h0000_C07F);
    chk(32'(nv_running), 32'h0000_0000);
    apb(1'b1, ADDR_KEY, 32'h0000_0055);
    apb(1'b1, ADDR_LO, 32'h0000_0000);
    apb(1'b1, ADDR_KEY, 32'h0000_00AA);
    apb(1'b1, ADDR_CTL, 32'h0000_C07F);
    chk(32'(nv_running), 32'h0000_0000);
    apb(1'b0, ADDR_KEY, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    foreach (CODES[i]) begin
      apb(1'b1, ADDR_CTL, {16'h0000, CODES[i]});
      unlock();
      apb(1'b1, ADDR_CTL, {16'h0000, CODES[i] | 16'h8000});
      chk(32'({nv_running, nv_op}), 32'(i + 17));
      chk(32'(nv_op), 32'(i + 1));
      apb(1'b1, ADDR_CTL, {16'h0000, CODES[i]});
      chk(32'({nv_running, nv_op}), 32'h0000_0000);
      apb(1'b1, ADDR_CTL, {16'h0000, CODES[i] | 16'h8000});
      chk(32'(nv_running), 32'h0000_0000);
    end
    apb(1'b1, ADDR_CTL, 32'h0000_4000);
    unlock();
    apb(1'b1, ADDR_CTL, 32'h0000_C000);
    chk(32'({nv_running, nv_op}), 32'h0000_0010);
    apb(1'b1, ADDR_CTL, 32'h0000_0000);
    ser(INS_WRITE, SEL_LO, 16'h0000);
    ser(INS_WRITE, SEL_HI, 16'h0080);
    ser(INS_STEP, SEL_LO, 16'h0040);
    chk({row_hi, row_lo}, 32'h0080_0040);
    ser(INS_WRITE, SEL_LO, 16'hFFC0);
    ser(INS_STEP, SEL_LO, 16'h0040);
    chk({row_hi, row_lo}, 32'h0081_0000);
    ser(INS_NOP, SEL_LO, 16'h1234);
    chk({row_hi, row_lo}, 32'h0081_0000);
    sfpc_prog_model_i.frame(4'h1, 24'h00_0000);
    ser(INS_WRITE, SEL_CTL, 16'h407F);
    ser(INS_WRITE, SEL_KEY, 16'h0055);
    ser(INS_WRITE, SEL_KEY, 16'h00AA);
    ser(INS_SET_START, SEL_CTL, 16'h0000);
    chk(32'({nv_running, nv_op}), 32'h0000_0011);
    // Programming time shortened; the programmer keeps it, not the block
    repeat (400) @(posedge clk);
    ser(INS_CLR_START, SEL_CTL, 16'h0000);
    apb(1'b0, ADDR_CTL, 32'h0000_0000);
    chk({nv_running, rd[30:0]}, 32'h0000_407F);
    wrap_up();
  end
endmodule // tb_sfpc

// [src/sfpc_pkg.sv]
// Constants, types and decode function of the serial flash program control
// Operation
// - Setting start bit begins erase/write cycle
// - Clearing start bit ends running cycle
// - Start bit writes blocked until key unlocks
// - Unlock is key writes 0x55 then 0xAA
// - Code 0x407F erases code and data memory
// - 0x4075 erases data row; 0x4074 one word
// - 0x4072 erases executive; 0x4071 code row
// - 0x406E/0x405E/0x404E erase nested segment sets
// - 0x4066/0x4056/0x4046 erase segment data EEPROM
// - 0x4008 writes config word; 0x4004 data word
// - 0x4005 writes data row; 0x4001 code row
// - Code 0000b LSB first then 24-bit instruction
// - Serial clock paces shifting and execution
package sfpc_pkg;

  // ****************************************************************
  // Register map (APB byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTL = 8'h00;
  localparam logic [7:0] ADDR_KEY = 8'h04;
  localparam logic [7:0] ADDR_LO = 8'h08;
  localparam logic [7:0] ADDR_HI = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam int START_BIT = 15;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  // ****************************************************************
  // Unlock key
  // ****************************************************************
  localparam logic [15:0] KEY_FIRST = 16'h0055;
  localparam logic [15:0] KEY_SECOND = 16'h00AA;
  localparam logic [1:0] KEY_LOCKED = 2'h0;
  localparam logic [1:0] KEY_HALF = 2'h1;
  localparam logic [1:0] KEY_OPEN = 2'h2;

  // ****************************************************************
  // Serial link
  // ****************************************************************
  localparam logic [3:0] CODE_EXEC = 4'h0;
  localparam logic [4:0] CODE_LAST = 5'h03;
  localparam logic [4:0] INSTR_LAST = 5'h17;
  // Instruction: [23:20] opcode, [19:16] register select, [15:0] data
  localparam logic [3:0] INS_NOP = 4'h0;
  localparam logic [3:0] INS_WRITE = 4'h1;
  localparam logic [3:0] INS_SET_START = 4'h2;
  localparam logic [3:0] INS_CLR_START = 4'h3;
  localparam logic [3:0] INS_STEP = 4'h4;
  localparam logic [3:0] SEL_CTL = 4'h0;
  localparam logic [3:0] SEL_KEY = 4'h1;
  localparam logic [3:0] SEL_LO = 4'h2;
  localparam logic [3:0] SEL_HI = 4'h3;

  typedef enum logic [1:0] {
    ST_CMD = 2'b01,
    ST_INSTR = 2'b10
  } sfpc_state_t;

  // ****************************************************************
  // Operations selected by the control value
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_BULK = 4'h1, OP_DROW = 4'h2, OP_DWORD = 4'h3,
    OP_EXEC = 4'h4, OP_CROW = 4'h5, OP_SEG_BSG = 4'h6, OP_SEG_SG = 4'h7,
    OP_SEG_G = 4'h8, OP_EE_B = 4'h9, OP_EE_S = 4'hA, OP_EE_G = 4'hB,
    OP_WCFG = 4'hC, OP_WDROW = 4'hD, OP_WDWORD = 4'hE, OP_WCROW = 4'hF
  } sfpc_op_t;

  function automatic sfpc_op_t sfpc_decode(input logic [14:0] v);
    unique case (v)
      15'h407F: sfpc_decode = OP_BULK;
      15'h4075: sfpc_decode = OP_DROW;
      15'h4074: sfpc_decode = OP_DWORD;
      15'h4072: sfpc_decode = OP_EXEC;
      15'h4071: sfpc_decode = OP_CROW;
      15'h406E: sfpc_decode = OP_SEG_BSG;
      15'h405E: sfpc_decode = OP_SEG_SG;
      15'h404E: sfpc_decode = OP_SEG_G;
      15'h4066: sfpc_decode = OP_EE_B;
      15'h4056: sfpc_decode = OP_EE_S;
      15'h4046: sfpc_decode = OP_EE_G;
      15'h4008: sfpc_decode = OP_WCFG;
      15'h4004: sfpc_decode = OP_WDWORD;
      15'h4005: sfpc_decode = OP_WDROW;
      15'h4001: sfpc_decode = OP_WCROW;
      default: sfpc_decode = OP_NONE;
    endcase
  endfunction

endpackage

// [src/sfpc_top.sv]
// Serial flash program control: serial link, registers, start interlock
module sfpc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Programmer link
  input wire logic prog_serial_clock,
  input wire logic prog_serial_data,
  // Nonvolatile array control
  output logic nv_running,
  output sfpc_pkg::sfpc_op_t nv_op,
  output logic [15:0] nv_row_addr_low,
  output logic [15:0] nv_row_addr_high
);
  import sfpc_pkg::*;

  typedef struct packed {
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic sdi_s1;
    logic sdi_s2;
    sfpc_state_t st;
    logic [4:0] cnt;
    logic [23:0] sh;
    logic exec;
    logic [23:0] ins;
    logic [15:0] ctl;
    logic [1:0] key;
    logic [15:0] lo;
    logic [15:0] hi;
    sfpc_op_t op;
    logic rdy;
    logic err;
    logic [31:0] rdata;
  } sfpc_regs_t;

  sfpc_regs_t r_q;
  sfpc_regs_t r_d;

  // ****************************************************************
  // Write port shared by APB and the serial instruction path
  // ****************************************************************
  logic apb_acc;
  logic apb_wr;
  logic ser_wr;
  logic wr_en;
  logic [3:0] wr_sel;
  logic [15:0] wr_data;
  logic sck_fall;
  logic [3:0] ins_op;
  logic [16:0] step_sum;

  assign apb_acc = psel && penable && r_q.rdy;
  assign apb_wr = apb_acc && pwrite;
  // Third stage only serves the edge finder; logic reads the second
  assign sck_fall = r_q.sck_s3 && !r_q.sck_s2;
  assign ins_op = r_q.ins[23:20];
  // Serial execution waits a cycle when APB writes at the same edge
  assign ser_wr = r_q.exec && !apb_wr;
  assign step_sum = {1'b0, r_q.lo} + {1'b0, r_q.ins[15:0]};

  always_comb begin
    wr_en = 1'b0;
    wr_sel = SEL_CTL;
    wr_data = r_q.ins[15:0];
    if (apb_wr) begin
      unique case (paddr)
        ADDR_CTL: begin
          wr_en = 1'b1;
          wr_sel = SEL_CTL;
        end
        ADDR_KEY: begin
          wr_en = 1'b1;
          wr_sel = SEL_KEY;
        end
        ADDR_LO: begin
          wr_en = 1'b1;
          wr_sel = SEL_LO;
        end
        ADDR_HI: begin
          wr_en = 1'b1;
          wr_sel = SEL_HI;
        end
        default: wr_en = 1'b0;
      endcase
      wr_data = pwdata[15:0];
    end else if (ser_wr) begin
      unique case (ins_op)
        INS_WRITE: begin
          wr_en = 1'b1;
          wr_sel = r_q.ins[19:16];
        end
        INS_SET_START: begin
          wr_en = 1'b1;
          wr_data = r_q.ctl | 16'h8000;
        end
        INS_CLR_START: begin
          wr_en = 1'b1;
          wr_data = r_q.ctl & 16'h7FFF;
        end
        default: wr_en = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    r_d = r_q;
    r_d.sck_s1 = prog_serial_clock;
    r_d.sck_s2 = r_q.sck_s1;
    r_d.sck_s3 = r_q.sck_s2;
    r_d.sdi_s1 = prog_serial_data;
    r_d.sdi_s2 = r_q.sdi_s1;
    if (ser_wr) begin
      r_d.exec = 1'b0;
    end

    // Bits are taken on the falling serial clock, LSB first
    if (sck_fall) begin
      r_d.sh = {r_q.sdi_s2, r_q.sh[23:1]};
      r_d.cnt = r_q.cnt + 5'h01;
      unique case (r_q.st)
        ST_CMD: begin
          if (r_q.cnt == CODE_LAST) begin
            r_d.cnt = 5'h00;
            // Only the execute code opens an instruction frame
            if ({r_q.sdi_s2, r_q.sh[23:21]} == CODE_EXEC) begin
              r_d.st = ST_INSTR;
            end
          end
        end
        ST_INSTR: begin
          if (r_q.cnt == INSTR_LAST) begin
            r_d.cnt = 5'h00;
            r_d.st = ST_CMD;
            r_d.ins = {r_q.sdi_s2, r_q.sh[23:1]};
            r_d.exec = 1'b1;
          end
        end
      endcase
    end

    // Any decoded register write other than the key sequence ruins the unlock; status and unmapped APB writes leave it
    if (wr_en) begin
      unique case (wr_sel)
        SEL_KEY: begin
          if (wr_data == KEY_FIRST) begin
            r_d.key = KEY_HALF;
          end else if (wr_data == KEY_SECOND && r_q.key == KEY_HALF) begin
            r_d.key = KEY_OPEN;
          end else begin
            r_d.key = KEY_LOCKED;
          end
        end
        SEL_CTL: begin
          r_d.ctl[14:0] = wr_data[14:0];
          r_d.key = KEY_LOCKED;
          if (!wr_data[START_BIT]) begin
            r_d.ctl[START_BIT] = 1'b0;
          end else if (!r_q.ctl[START_BIT] && r_q.key == KEY_OPEN) begin
            r_d.ctl[START_BIT] = 1'b1;
          end
        end
        SEL_LO: begin
          r_d.lo = wr_data;
          r_d.key = KEY_LOCKED;
        end
        SEL_HI: begin
          r_d.hi = wr_data;
          r_d.key = KEY_LOCKED;
        end
        default: r_d.key = KEY_LOCKED;
      endcase
    end else if (ser_wr && ins_op == INS_STEP) begin
      // Row step with carry into the high address
      r_d.lo = step_sum[15:0];
      r_d.hi = r_q.hi + {15'h0000, step_sum[16]};
      r_d.key = KEY_LOCKED;
    end

    r_d.op = r_d.ctl[START_BIT] ? sfpc_decode(r_d.ctl[14:0]) : OP_NONE;

    // ****************************************************************
    // APB answer: one wait state
    // ****************************************************************
    r_d.rdy = psel && penable && !r_q.rdy;
    r_d.err = 1'b0;
    r_d.rdata = 32'h0000_0000;
    if (psel && penable && !r_q.rdy) begin
      unique case (paddr)
        ADDR_CTL: r_d.rdata = {16'h0000, r_q.ctl};
        ADDR_KEY: r_d.rdata = 32'h0000_0000;
        ADDR_LO: r_d.rdata = {16'h0000, r_q.lo};
        ADDR_HI: r_d.rdata = {16'h0000, r_q.hi};
        ADDR_STAT: begin
          r_d.rdata = {23'h00_0000, r_q.st == ST_INSTR, r_q.exec,
                       r_q.key, r_q.op, r_q.ctl[START_BIT]};
        end
        default: r_d.err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_q <= '{st: ST_CMD, op: OP_NONE, ctl: CTL_RESET, lo: ADDR_RESET,
               hi: ADDR_RESET, key: KEY_LOCKED, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata = r_q.rdata;
  assign pready = r_q.rdy;
  assign pslverr = r_q.err;
  assign nv_running = r_q.ctl[START_BIT];
  assign nv_op = r_q.op;
  assign nv_row_addr_low = r_q.lo;
  assign nv_row_addr_high = r_q.hi;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_start_needs_key: assert property (
    $rose(r_q.ctl[START_BIT]) |-> $past(r_q.key) == KEY_OPEN)
    else $error("Start bit rose without unlock");
  a_start_sets: assert property (
    wr_en && wr_sel == SEL_CTL && wr_data[START_BIT] &&
    r_q.key == KEY_OPEN |=> r_q.ctl[START_BIT])
    else $error("Unlocked start write did not start cycle");
  a_stop_clears: assert property (
    wr_en && wr_sel == SEL_CTL && !wr_data[START_BIT]
    |=> !r_q.ctl[START_BIT] && r_q.op == OP_NONE)
    else $error("Clearing start bit did not end cycle");
  a_relock_after: assert property (
    $rose(r_q.ctl[START_BIT]) |-> r_q.key == KEY_LOCKED)
    else $error("Lock not re-engaged after start");
  a_key_order: assert property (
    r_q.key == KEY_OPEN && !$past(r_q.key == KEY_OPEN)
    |-> $past(r_q.key) == KEY_HALF && $past(wr_data) == KEY_SECOND)
    else $error("Unlock reached without 0x55 then 0xAA");
  a_bulk_decode: assert property (
    r_q.ctl == 16'hC07F |-> r_q.op == OP_BULK)
    else $error("Bulk erase value not decoded");
  a_crow_decode: assert property (
    r_q.ctl == 16'hC071 |-> r_q.op == OP_CROW)
    else $error("Code row erase value not decoded");
  a_instr_exec: assert property (
    sck_fall && r_q.st == ST_INSTR && r_q.cnt == INSTR_LAST
    |=> r_q.exec && r_q.st == ST_CMD)
    else $error("Instruction not executed after 24 bits");
  a_code_frame: assert property (
    r_q.st == ST_CMD ##1 r_q.st == ST_INSTR
    |-> $past(sck_fall) && $past(r_q.cnt) == CODE_LAST)
    else $error("Instruction frame opened off a code boundary");
  a_apb_wait: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer not after one wait state");

  // ****************************************************************
  // Decode of eight further control values while the cycle runs
  // ****************************************************************
  a_drow_decode: assert property (
    r_q.ctl == 16'hC075 |-> r_q.op == OP_DROW)
    else $error("Data row erase value not decoded");
  a_dword_decode: assert property (
    r_q.ctl == 16'hC074 |-> r_q.op == OP_DWORD)
    else $error("Data word erase value not decoded");
  a_exec_decode: assert property (
    r_q.ctl == 16'hC072 |-> r_q.op == OP_EXEC)
    else $error("Executive erase value not decoded");
  a_seg_decode: assert property (
    r_q.ctl == 16'hC06E |-> r_q.op == OP_SEG_BSG)
    else $error("Segment erase value not decoded");
  a_gseg_decode: assert property (
    r_q.ctl == 16'hC04E |-> r_q.op == OP_SEG_G)
    else $error("General segment erase value not decoded");
  a_eeseg_decode: assert property (
    r_q.ctl == 16'hC066 |-> r_q.op == OP_EE_B)
    else $error("Segment data erase value not decoded");
  a_wcfg_decode: assert property (
    r_q.ctl == 16'hC008 |-> r_q.op == OP_WCFG)
    else $error("Config word write value not decoded");
  a_wcrow_decode: assert property (
    r_q.ctl == 16'hC001 |-> r_q.op == OP_WCROW)
    else $error("Code row write value not decoded");

  // ****************************************************************
  // Interlock, link and bus
  // ****************************************************************
  a_locked_ignored: assert property (
    wr_en && wr_sel == SEL_CTL && wr_data[START_BIT] &&
    r_q.key != KEY_OPEN && !r_q.ctl[START_BIT] |=> !r_q.ctl[START_BIT])
    else $error("Start bit set while locked");
  a_other_relocks: assert property (
    wr_en && wr_sel != SEL_KEY |=> r_q.key == KEY_LOCKED)
    else $error("Lock survived a non-key write");
  a_idle_no_op: assert property (
    !r_q.ctl[START_BIT] |-> r_q.op == OP_NONE)
    else $error("Operation shown while no cycle runs");
  a_bit_taken: assert property (
    sck_fall |=> r_q.sh[23] == $past(r_q.sdi_s2))
    else $error("Serial bit not taken on falling clock");
  a_row_step: assert property (
    ser_wr && ins_op == INS_STEP |=>
    {r_q.hi, r_q.lo} == $past({r_q.hi, r_q.lo} + {16'h0000, r_q.ins[15:0]}))
    else $error("Row step did not add with carry");
  a_err_with_ready: assert property (
    pslverr |-> pready)
    else $error("Bus error shown outside an answer");
  a_apb_write: assert property (
    apb_wr && paddr == ADDR_LO |=> r_q.lo == $past(pwdata[15:0]))
    else $error("Bus write to row low address lost");

  // ****************************************************************
  // Scenarios reached
  // ****************************************************************
  c_unlock_start: cover property (
    r_q.key == KEY_HALF ##[1:300] r_q.key == KEY_OPEN ##[1:300]
    r_q.ctl[START_BIT]);
  c_locked_start: cover property (
    wr_en && wr_sel == SEL_CTL && wr_data[START_BIT] &&
    r_q.key != KEY_OPEN);
  c_serial_exec: cover property (ser_wr && ins_op == INS_SET_START);
  c_step_carry: cover property (
    ser_wr && ins_op == INS_STEP && step_sum[16]);
  c_bulk_run: cover property (r_q.op == OP_BULK);

endmodule // sfpc_top
